// [rtl/async_channel.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Empty-FIFO timer expiry posts timeout exception.
// - Timeout exception only once per empty spell.
// - No timer start after exception removal.
// - Exception puts status then data in FIFO.
// - One exception request per exception character.
// - Good data ahead of exception requested early.
// - Exception request follows end of good service.
// - End of exception service drops whole pair.
// - One null break entry per line break.
// - Optional end-of-break null entry.
// - Reset disables transmitter, line held mark.
// - Enabled transmitter requests data at once.
// - Transmission waits for end of service.
// - Start, 5-8 data LSB first, parity, stop.
// - Back-to-back characters, request when drained.
// - Twelve FIFO locations, plus holding and shift registers.
// - Request on FIFO empty or shifter empty.
// - Underrun keeps sending mark.
// - Disable finishes character, holds rest.
// - Delay entries count prescaler ticks.
// - Receive timer reload and prescaler countdown.
// - Stale data timeout posts good request.
module async_channel
    import uart_chan_pkg::*;
#(
    parameter int RX_DEPTH = RX_FIFO_DEPTH,
    parameter int TX_DEPTH = TX_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire logic prescaleTick,
    input wire logic bitTick,
    input wire rx_char_type rxChar,
    output logic serialOut,
    output logic [2:0] serviceReq
);

    localparam int IW = $clog2(RX_DEPTH > TX_DEPTH ? RX_DEPTH : TX_DEPTH);
    localparam int CW = IW + 1;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        return adr[7:2] == off[7:2];
    endfunction

    function automatic logic [IW-1:0] wrapAdd(input logic [IW-1:0] idx, input logic [1:0] n,
                                              input logic [IW:0] depth);
        logic [IW:0] sum;
        sum = {1'b0, idx} + {{(IW - 1){1'b0}}, n};
        if (sum >= depth) begin
            sum = sum - depth;
        end
        return sum[IW-1:0];
    endfunction

    // ****************************************************************
    // Bus slave and configuration.
    // ****************************************************************
    logic busReq, wrReq, rdReq, masterReset, softClr, eosWr;
    logic txEnabled, stale, nndtDone, rxRun, brkPrev, holdValid;
    logic [3:0] sre, threshold;
    logic [4:0] optFmt;
    logic [7:0] opt5, rxPeriod, rxTimer, txTimer;
    logic [1:0] excReads;
    svc_type svcState;
    txs_type txState;
    rx_entry_type rxMem [RX_DEPTH];
    rx_entry_type rxHead, pushA, pushB;
    tx_entry_type txMem [TX_DEPTH];
    tx_entry_type hold;
    logic [IW-1:0] rxRd, rxWr, txRd, txWr;
    logic [CW-1:0] rxCount, goodCount, excPairs, txCount;
    logic [1:0] pushN, popN;
    logic pushOk, pushReal, pushTmo, hostPop, endPop, canRead, timerFire;

    assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wrReq = busReq & wb_we_i & wb_sel_i[0];
    assign rdReq = busReq & ~wb_we_i;
    assign masterReset = wrReq & hit(wb_adr_i, ADR_CMD) & wb_dat_i[CMD_RESET];
    assign softClr = srst | masterReset;
    assign eosWr = wrReq & hit(wb_adr_i, ADR_EOS);

    always_ff @(posedge clk) begin
        wb_ack_o <= srst ? 1'b0 : busReq;
    end

    always_ff @(posedge clk) begin
        if (softClr) begin
            sre <= SRE_RST;
            optFmt <= OPT_RST;
            opt5 <= OPT5_RST;
            threshold <= THRESH_RST;
            rxPeriod <= RXTMO_RST;
        end else if (wrReq) begin
            if (hit(wb_adr_i, ADR_SRE)) sre <= wb_dat_i[3:0];
            if (hit(wb_adr_i, ADR_OPT)) optFmt <= wb_dat_i[4:0];
            if (hit(wb_adr_i, ADR_OPT5)) opt5 <= wb_dat_i[7:0];
            if (hit(wb_adr_i, ADR_THRESH)) threshold <= wb_dat_i[3:0];
            if (hit(wb_adr_i, ADR_RXTMO)) rxPeriod <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (softClr) begin
            txEnabled <= 1'b0;
        end else if (wrReq && hit(wb_adr_i, ADR_CMD)) begin
            if (wb_dat_i[CMD_TX_DIS]) txEnabled <= 1'b0;
            else if (wb_dat_i[CMD_TX_EN]) txEnabled <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rdReq) begin
            wb_dat_o <= 32'h0000_0000;
            if (hit(wb_adr_i, ADR_CMD)) wb_dat_o[CMD_TX_EN] <= txEnabled;
            if (hit(wb_adr_i, ADR_SRE)) wb_dat_o[3:0] <= sre;
            if (hit(wb_adr_i, ADR_OPT)) wb_dat_o[4:0] <= optFmt;
            if (hit(wb_adr_i, ADR_OPT5)) wb_dat_o[7:0] <= opt5;
            if (hit(wb_adr_i, ADR_THRESH)) wb_dat_o[3:0] <= threshold;
            if (hit(wb_adr_i, ADR_RXTMO)) wb_dat_o[7:0] <= rxPeriod;
            if (hit(wb_adr_i, ADR_STATUS)) begin
                wb_dat_o[15:0] <= {2'h0, svcState, txCount[3:0], rxCount[3:0], txEnabled, serviceReq};
            end
            if (hit(wb_adr_i, ADR_RXDATA) && canRead) wb_dat_o[7:0] <= rxHead.value;
        end
    end

    // ****************************************************************
    // Service request and acknowledge.
    // ****************************************************************
    logic next_goodReq, next_excReq, next_txReq;

    always_ff @(posedge clk) begin
        if (softClr) begin
            svcState <= SVC_IDLE;
        end else if (eosWr) begin
            svcState <= SVC_IDLE;
        end else if (wrReq && hit(wb_adr_i, ADR_SVCACK) && svcState == SVC_IDLE) begin
            case (wb_dat_i[1:0])
                ACK_RXGOOD: if (serviceReq[0]) svcState <= SVC_RXGOOD;
                ACK_RXEXC: if (serviceReq[1]) svcState <= SVC_RXEXC;
                ACK_TX: if (serviceReq[2]) svcState <= SVC_TX;
                default: svcState <= SVC_IDLE;
            endcase
        end
    end

    always_comb begin
        rxHead = rxMem[rxRd];
        next_goodReq = sre[SRE_RX] && svcState == SVC_IDLE && rxCount != '0
            && rxHead.kind == KIND_GOOD
            && (goodCount >= CW'(threshold) || excPairs != '0 || stale);
        next_excReq = sre[SRE_RX] && svcState == SVC_IDLE && rxCount != '0
            && rxHead.kind == KIND_STAT;
        next_txReq = sre[SRE_TX] && txEnabled && svcState == SVC_IDLE && txCount == '0
            && (!sre[SRE_TX_SHIFT] || (!holdValid && txState != TX_START
            && txState != TX_DATA && txState != TX_DELAY));
    end

    always_ff @(posedge clk) begin
        serviceReq <= softClr ? 3'h0 : {next_txReq, next_excReq, next_goodReq};
    end

    // ****************************************************************
    // Receive FIFO with status and data pairs.
    // ****************************************************************
    logic brkRise, brkEnd, emptiedNow, lastPopExc;

    assign brkRise = rxChar.lineBreak & ~brkPrev;
    assign brkEnd = ~rxChar.lineBreak & brkPrev & opt5[OPT5_EOB];
    assign timerFire = rxRun & prescaleTick & (rxTimer <= 8'h01);

    always_comb begin
        pushN = 2'h0;
        pushA = '{KIND_GOOD, 8'h00};
        pushB = '{KIND_EXDAT, 8'h00};
        pushReal = 1'b0;
        pushTmo = 1'b0;
        if (brkRise) begin
            pushN = 2'h2;
            pushA = '{KIND_STAT, ST_BREAK};
            pushReal = 1'b1;
        end else if (brkEnd) begin
            pushN = 2'h2;
            pushA = '{KIND_STAT, ST_EOB};
            pushReal = 1'b1;
        end else if (rxChar.valid && !rxChar.lineBreak) begin
            pushReal = 1'b1;
            if (rxChar.framingErr || rxChar.parityErr) begin
                pushN = 2'h2;
                pushA = '{KIND_STAT, (rxChar.framingErr ? ST_FRAME : 8'h00)
                    | (rxChar.parityErr ? ST_PARITY : 8'h00)};
                pushB = '{KIND_EXDAT, rxChar.data};
            end else begin
                pushN = 2'h1;
                pushA = '{KIND_GOOD, rxChar.data};
            end
        end else if (timerFire && rxCount == '0 && sre[SRE_NO_NEW_DATA_TIMEOUT] && !nndtDone) begin
            pushN = 2'h2;
            pushA = '{KIND_STAT, ST_TIMEOUT};
            pushTmo = 1'b1;
        end
        pushOk = pushN != 2'h0 && (CW'(RX_DEPTH) - rxCount) >= CW'(pushN);
    end

    assign canRead = rxCount != '0 && ((svcState == SVC_RXGOOD && rxHead.kind == KIND_GOOD)
        || (svcState == SVC_RXEXC && excReads != 2'h2));
    assign hostPop = rdReq & hit(wb_adr_i, ADR_RXDATA) & canRead;
    assign endPop = eosWr & (svcState == SVC_RXEXC);
    assign popN = hostPop ? 2'h1 : (endPop ? 2'h2 - excReads : 2'h0);
    assign lastPopExc = hostPop ? rxHead.kind != KIND_GOOD : 1'b1;
    assign emptiedNow = popN != 2'h0 && rxCount == CW'(popN) && !pushOk;

    always_ff @(posedge clk) begin
        if (pushOk) begin
            rxMem[rxWr] <= pushA;
            if (pushN == 2'h2) rxMem[wrapAdd(rxWr, 2'h1, (IW + 1)'(RX_DEPTH))] <= pushB;
        end
    end

    always_ff @(posedge clk) begin
        if (softClr) begin
            rxRd <= '0;
            rxWr <= '0;
            rxCount <= '0;
            goodCount <= '0;
            excPairs <= '0;
        end else begin
            if (pushOk) rxWr <= wrapAdd(rxWr, pushN, (IW + 1)'(RX_DEPTH));
            rxRd <= wrapAdd(rxRd, popN, (IW + 1)'(RX_DEPTH));
            rxCount <= rxCount + (pushOk ? CW'(pushN) : '0) - CW'(popN);
            goodCount <= goodCount + CW'(pushOk && pushN == 2'h1)
                - CW'(hostPop && rxHead.kind == KIND_GOOD);
            excPairs <= excPairs + CW'(pushOk && pushN == 2'h2) - CW'(endPop);
        end
    end

    always_ff @(posedge clk) begin
        if (softClr || (wrReq && hit(wb_adr_i, ADR_SVCACK))) excReads <= 2'h0;
        else if (hostPop && svcState == SVC_RXEXC) excReads <= excReads + 2'h1;
    end

    always_ff @(posedge clk) begin
        brkPrev <= softClr ? 1'b0 : rxChar.lineBreak;
    end

    // ****************************************************************
    // Receive timer.
    // ****************************************************************
    // Reload and countdown.
    always_ff @(posedge clk) begin
        if (softClr) begin
            rxRun <= 1'b0;
            rxTimer <= 8'h00;
        end else if (pushOk && pushReal) begin
            rxRun <= 1'b1;
            rxTimer <= rxPeriod;
        end else if (emptiedNow) begin
            rxRun <= !lastPopExc;
            rxTimer <= rxPeriod;
        end else if (timerFire) begin
            rxRun <= 1'b0;
        end else if (rxRun && prescaleTick) begin
            rxTimer <= rxTimer - 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (softClr || (pushOk && pushReal)) nndtDone <= 1'b0;
        else if (pushOk && pushTmo) nndtDone <= 1'b1;
    end

    always_ff @(posedge clk) begin
        if (softClr) stale <= 1'b0;
        else if (timerFire && rxCount != '0 && goodCount < CW'(threshold)) stale <= 1'b1;
        else if (eosWr && svcState == SVC_RXGOOD) stale <= 1'b0;
    end

    // ****************************************************************
    // Transmit FIFO, holding register and bit engine.
    // ****************************************************************
    logic txPush, moveHold, lastStop, takeHold, txPar, stopCnt;
    logic [7:0] txShift;
    logic [2:0] bitCnt, lastBit;

    assign txPush = wrReq & (hit(wb_adr_i, ADR_TXDATA) | hit(wb_adr_i, ADR_TXDELAY))
        & (txCount < CW'(TX_DEPTH));
    assign moveHold = !holdValid && txCount != '0 && svcState != SVC_TX;
    assign lastStop = txState == TX_STOP && bitTick && stopCnt == optFmt[OPT_STOP2];
    assign takeHold = holdValid && txEnabled && (txState == TX_IDLE || lastStop);
    assign lastBit = {1'b0, optFmt[OPT_LEN_HI:OPT_LEN_LO]} + 3'h4;

    always_ff @(posedge clk) begin
        if (txPush) txMem[txWr] <= '{hit(wb_adr_i, ADR_TXDELAY), wb_dat_i[7:0]};
    end

    always_ff @(posedge clk) begin
        if (softClr) begin
            txRd <= '0;
            txWr <= '0;
            txCount <= '0;
            holdValid <= 1'b0;
            hold <= '{1'b0, 8'h00};
        end else begin
            if (txPush) txWr <= wrapAdd(txWr, 2'h1, (IW + 1)'(TX_DEPTH));
            if (moveHold) begin
                txRd <= wrapAdd(txRd, 2'h1, (IW + 1)'(TX_DEPTH));
                hold <= txMem[txRd];
                holdValid <= 1'b1;
            end else if (takeHold) begin
                holdValid <= 1'b0;
            end
            txCount <= txCount + CW'(txPush) - CW'(moveHold);
        end
    end

    always_ff @(posedge clk) begin
        if (softClr) begin
            txState <= TX_IDLE;
            serialOut <= 1'b1;
            txShift <= 8'h00;
            bitCnt <= 3'h0;
            txPar <= 1'b0;
            stopCnt <= 1'b0;
            txTimer <= 8'h00;
        end else if (takeHold) begin
            if (hold.isDelay) begin
                txState <= TX_DELAY;
                txTimer <= hold.value;
                serialOut <= 1'b1;
            end else begin
                txState <= TX_START;
                txShift <= hold.value;
                txPar <= optFmt[OPT_PAR_ODD];
                serialOut <= 1'b0;
            end
        end else begin
            case (txState)
                TX_START: if (bitTick) begin
                    serialOut <= txShift[0];
                    txPar <= txPar ^ txShift[0];
                    txShift <= {1'b0, txShift[7:1]};
                    bitCnt <= 3'h0;
                    txState <= TX_DATA;
                end
                TX_DATA: if (bitTick) begin
                    if (bitCnt == lastBit) begin
                        serialOut <= optFmt[OPT_PAR_EN] ? txPar : 1'b1;
                        txState <= optFmt[OPT_PAR_EN] ? TX_PARITY : TX_STOP;
                        stopCnt <= 1'b0;
                    end else begin
                        serialOut <= txShift[0];
                        txPar <= txPar ^ txShift[0];
                        txShift <= {1'b0, txShift[7:1]};
                        bitCnt <= bitCnt + 3'h1;
                    end
                end
                TX_PARITY: if (bitTick) begin
                    serialOut <= 1'b1;
                    txState <= TX_STOP;
                end
                TX_STOP: if (bitTick) begin
                    stopCnt <= 1'b1;
                    if (lastStop) txState <= TX_IDLE;
                end
                TX_DELAY: if (prescaleTick) begin
                    if (txTimer <= 8'h01) txState <= TX_IDLE;
                    else txTimer <= txTimer - 8'h01;
                end
                default: begin
                    serialOut <= 1'b1;
                    txState <= TX_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    a_reset_mark: assert property (@(posedge clk) disable iff (srst)
        masterReset |=> serialOut && !txEnabled && txState == TX_IDLE)
        else $error("Master reset left the line or transmitter active.");

    a_no_new_data_timeout_cause: assert property (@(posedge clk) disable iff (srst)
        (pushOk && pushTmo) |-> sre[SRE_NO_NEW_DATA_TIMEOUT] && rxCount == '0 ##1 rxCount == CW'(2))
        else $error("Timeout entry posted without its cause.");

    a_no_new_data_timeout_once: assert property (@(posedge clk) disable iff (srst)
        (pushOk && pushTmo) |=> nndtDone && !(pushOk && pushTmo))
        else $error("Timeout entry repeated.");

    a_exc_pair: assert property (@(posedge clk) disable iff (srst)
        (rxChar.valid && !rxChar.lineBreak && !brkPrev && (rxChar.framingErr || rxChar.parityErr))
        |-> pushN == 2'h2 && pushA.kind == KIND_STAT && pushB.value == rxChar.data)
        else $error("Exception character not stored as a pair.");

    a_early_good: assert property (@(posedge clk) disable iff (srst)
        (sre[SRE_RX] && svcState == SVC_IDLE && !eosWr && rxCount != '0 && excPairs != '0
        && rxHead.kind == KIND_GOOD) |=> serviceReq[0])
        else $error("Good data ahead of exception not requested.");

    a_pair_drop: assert property (@(posedge clk) disable iff (srst)
        endPop |=> rxRd == wrapAdd($past(rxRd), 2'h2 - $past(excReads), (IW + 1)'(RX_DEPTH)))
        else $error("Exception pair not fully removed.");

    a_tx_enable: assert property (@(posedge clk) disable iff (srst)
        ($rose(txEnabled) && sre[SRE_TX] && !sre[SRE_TX_SHIFT] && txCount == '0
        && svcState == SVC_IDLE && !wrReq) |=> serviceReq[2])
        else $error("Enabled transmitter did not request data.");

    a_svc_hold: assert property (@(posedge clk) disable iff (srst)
        (svcState == SVC_TX && !holdValid && txState == TX_IDLE && !eosWr)
        |=> !holdValid && serialOut)
        else $error("Transmission started during service.");

    a_start_bit: assert property (@(posedge clk) disable iff (srst)
        (takeHold && !hold.isDelay) |=> !serialOut && txState == TX_START)
        else $error("Character did not begin with a start bit.");

    a_idle_mark: assert property (@(posedge clk) disable iff (srst)
        txState == TX_IDLE |-> serialOut)
        else $error("Idle line not at mark.");

endmodule

// [rtl/uart_chan_pkg.sv]
package uart_chan_pkg;

    localparam int RX_FIFO_DEPTH = 12;
    localparam int TX_FIFO_DEPTH = 12;

    // ****************************************************************
    // Register byte addresses.
    // ****************************************************************
    localparam logic [7:0] ADR_CMD = 8'h00;
    localparam logic [7:0] ADR_SRE = 8'h04;
    localparam logic [7:0] ADR_OPT = 8'h08;
    localparam logic [7:0] ADR_OPT5 = 8'h0C;
    localparam logic [7:0] ADR_THRESH = 8'h10;
    localparam logic [7:0] ADR_RXTMO = 8'h14;
    localparam logic [7:0] ADR_STATUS = 8'h18;
    localparam logic [7:0] ADR_SVCACK = 8'h1C;
    localparam logic [7:0] ADR_EOS = 8'h20;
    localparam logic [7:0] ADR_RXDATA = 8'h24;
    localparam logic [7:0] ADR_TXDATA = 8'h28;
    localparam logic [7:0] ADR_TXDELAY = 8'h2C;

    // ****************************************************************
    // Field positions, reset values and codes.
    // ****************************************************************
    localparam int CMD_TX_EN = 0;
    localparam int CMD_TX_DIS = 1;
    localparam int CMD_RESET = 2;
    localparam int SRE_NO_NEW_DATA_TIMEOUT = 0;
    localparam int SRE_RX = 1;
    localparam int SRE_TX = 2;
    localparam int SRE_TX_SHIFT = 3;
    localparam int OPT_LEN_LO = 0;
    localparam int OPT_LEN_HI = 1;
    localparam int OPT_PAR_EN = 2;
    localparam int OPT_PAR_ODD = 3;
    localparam int OPT_STOP2 = 4;
    localparam int OPT5_EOB = 2;
    localparam logic [3:0] SRE_RST = 4'h0;
    localparam logic [4:0] OPT_RST = 5'h03;
    localparam logic [7:0] OPT5_RST = 8'h00;
    localparam logic [3:0] THRESH_RST = 4'h8;
    localparam logic [7:0] RXTMO_RST = 8'hFF;
    localparam logic [7:0] ST_BREAK = 8'h01;
    localparam logic [7:0] ST_EOB = 8'h02;
    localparam logic [7:0] ST_TIMEOUT = 8'h04;
    localparam logic [7:0] ST_FRAME = 8'h08;
    localparam logic [7:0] ST_PARITY = 8'h10;
    localparam logic [1:0] KIND_GOOD = 2'h0;
    localparam logic [1:0] KIND_STAT = 2'h1;
    localparam logic [1:0] KIND_EXDAT = 2'h2;
    localparam logic [1:0] ACK_RXGOOD = 2'h1;
    localparam logic [1:0] ACK_RXEXC = 2'h2;
    localparam logic [1:0] ACK_TX = 2'h3;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic framingErr;
        logic parityErr;
        logic lineBreak;
    } rx_char_type;

    typedef struct packed {
        logic [1:0] kind;
        logic [7:0] value;
    } rx_entry_type;

    typedef struct packed {
        logic isDelay;
        logic [7:0] value;
    } tx_entry_type;

    typedef enum logic [1:0] {SVC_IDLE, SVC_RXGOOD, SVC_RXEXC, SVC_TX} svc_type;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP, TX_DELAY} txs_type;

endpackage

// [verification/remote_term.sv]
`timescale 1ns/1ps
// ****
// Remote terminal model.
// ****
module remote_term
    import uart_chan_pkg::*;
(
    input wire logic clk,
    input wire logic bitTick,
    input wire logic serialOut,
    output rx_char_type rxChar
);
    logic [7:0] sh = 8'h00;
    int cnt = 0;
    logic [7:0] got[$];
    initial rxChar = '0;
    always @(posedge clk) begin
        if (bitTick) begin
            if (cnt == 0) begin
                if (!serialOut) cnt <= 1;
            end else if (cnt < 9) begin
                sh <= {serialOut, sh[7:1]};
                cnt <= cnt + 1;
            end else begin
                if (serialOut) got.push_back(sh);
                cnt <= 0;
            end
        end
    end
    // The data lines are scrambled outside the valid pulse so stale bytes cannot pass.
    task automatic send(input logic [7:0] d, input logic par);
        @(posedge clk);
        rxChar <= '{1'b1, d, 1'b0, par, 1'b0};
        @(posedge clk);
        rxChar <= '{1'b0, ~d, 1'b0, 1'b0, 1'b0};
    endtask
    task automatic line_break(input int len);
        @(posedge clk);
        rxChar <= '{1'b0, 8'h00, 1'b0, 1'b0, 1'b1};
        repeat (len) @(posedge clk);
        rxChar <= '0;
    endtask
endmodule

// [verification/tb.sv]
`timescale 1ns/1ps
module tb
    import uart_chan_pkg::*;
;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic prescaleTick = 1'b0;
    logic bitTick = 1'b0;
    logic [2:0] tk = 3'h0;
    logic ack;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic serialOut;
    logic [2:0] serviceReq;
    rx_char_type rxChar;
    int err_total = 0;
    int comparisons = 0;
    int k;
    async_channel dut_u (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_ack_o(ack),
        .wb_dat_o(rdat), .prescaleTick(prescaleTick), .bitTick(bitTick), .rxChar(rxChar),
        .serialOut(serialOut), .serviceReq(serviceReq));
    remote_term rem_u (.clk(clk), .bitTick(bitTick), .serialOut(serialOut), .rxChar(rxChar));
    initial forever #10 clk = ~clk;
    always @(posedge clk) begin
        tk <= tk + 3'h1;
        bitTick <= tk == 3'h7;
        prescaleTick <= tk[1:0] == 2'h3;
    end
    task automatic close_out;
        $display("Counts: %0d mismatches, %0d comparisons", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) chk("bus ack", 32'h1, 32'h0);
        if (n >= 50) close_out();
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wait_req(input int b, input int lim);
        int n;
        for (n = 0; n < lim && serviceReq[b] !== 1'b1; n++) @(posedge clk);
        chk("request", 32'h1, {31'h0, serviceReq[b]});
        if (n >= lim) close_out();
    endtask
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        chk("line idle", 32'h1, {31'h0, serialOut});
        chk("no request", 32'h0, {29'h0, serviceReq});
        bus(1'b1, ADR_RXTMO, 32'h4);
        bus(1'b1, ADR_SRE, 32'h6);
        bus(1'b1, ADR_CMD, 32'h1);
        wait_req(2, 4);
        bus(1'b1, ADR_SVCACK, {30'h0, ACK_TX});
        bus(1'b1, ADR_TXDATA, 32'hA5);
        bus(1'b1, ADR_TXDATA, 32'h3C);
        chk("held", 32'h1, {31'h0, serialOut});
        bus(1'b1, ADR_EOS, 32'h0);
        for (int i = 0; i < 400 && rem_u.got.size() < 2; i++) @(posedge clk);
        chk("tx byte 0", 32'hA5, {24'h0, rem_u.got[0]});
        chk("tx byte 1", 32'h3C, {24'h0, rem_u.got[1]});
        chk("underrun mark", 32'h1, {31'h0, serialOut});
        chk("drained request", 32'h1, {31'h0, serviceReq[2]});
        $display("test transmit done");
        bus(1'b1, ADR_SRE, 32'h3);
        rem_u.send(8'h11, 1'b0);
        rem_u.send(8'h22, 1'b1);
        wait_req(0, 6);
        bus(1'b1, ADR_SVCACK, {30'h0, ACK_RXGOOD});
        bus(1'b0, ADR_RXDATA, 32'h0);
        chk("good data", 32'h11, rd);
        bus(1'b1, ADR_EOS, 32'h0);
        wait_req(1, 10);
        bus(1'b1, ADR_SVCACK, {30'h0, ACK_RXEXC});
        bus(1'b0, ADR_RXDATA, 32'h0);
        chk("parity status", {24'h0, ST_PARITY}, rd);
        bus(1'b1, ADR_EOS, 32'h0);
        bus(1'b0, ADR_STATUS, 32'h0);
        chk("rx entries", 32'h0, {28'h0, rd[7:4]});
        repeat (60) @(posedge clk);
        chk("no timeout", 32'h0, {29'h0, serviceReq});
        $display("test exception done");
        rem_u.send(8'h33, 1'b0);
        wait_req(0, 100);
        bus(1'b1, ADR_SVCACK, {30'h0, ACK_RXGOOD});
        bus(1'b0, ADR_RXDATA, 32'h0);
        chk("stale data", 32'h33, rd);
        bus(1'b1, ADR_EOS, 32'h0);
        wait_req(1, 100);
        bus(1'b1, ADR_SVCACK, {30'h0, ACK_RXEXC});
        bus(1'b0, ADR_RXDATA, 32'h0);
        chk("timeout status", {24'h0, ST_TIMEOUT}, rd);
        bus(1'b1, ADR_EOS, 32'h0);
        repeat (60) @(posedge clk);
        chk("single timeout", 32'h0, {29'h0, serviceReq});
        $display("test timeout done");
        bus(1'b1, ADR_OPT5, 32'h4);
        rem_u.line_break(20);
        wait_req(1, 10);
        bus(1'b1, ADR_SVCACK, {30'h0, ACK_RXEXC});
        bus(1'b0, ADR_RXDATA, 32'h0);
        chk("break status", {24'h0, ST_BREAK}, rd);
        bus(1'b0, ADR_RXDATA, 32'h0);
        chk("break null", 32'h0, rd);
        bus(1'b1, ADR_EOS, 32'h0);
        wait_req(1, 10);
        bus(1'b1, ADR_SVCACK, {30'h0, ACK_RXEXC});
        bus(1'b0, ADR_RXDATA, 32'h0);
        chk("end of break", {24'h0, ST_EOB}, rd);
        bus(1'b1, ADR_EOS, 32'h0);
        bus(1'b0, ADR_STATUS, 32'h0);
        chk("one break entry", 32'h0, {28'h0, rd[7:4]});
        $display("test break done");
        bus(1'b1, ADR_CMD, 32'h4);
        bus(1'b0, ADR_CMD, 32'h0);
        chk("master reset", 32'h0, rd);
        bus(1'b1, ADR_SRE, 32'hC);
        bus(1'b1, ADR_CMD, 32'h1);
        wait_req(2, 4);
        bus(1'b1, ADR_SVCACK, {30'h0, ACK_TX});
        bus(1'b1, ADR_TXDELAY, 32'h3);
        bus(1'b1, ADR_TXDATA, 32'h5A);
        bus(1'b1, ADR_TXDATA, 32'h96);
        bus(1'b1, ADR_EOS, 32'h0);
        for (k = 0; k < 100 && serialOut !== 1'b0; k++) @(posedge clk);
        chk("delay cycles", 32'h1, {31'h0, k >= 9});
        bus(1'b1, ADR_CMD, 32'h2);
        repeat (250) @(posedge clk);
        chk("held count", 32'h3, rem_u.got.size());
        chk("last before hold", 32'h5A, {24'h0, rem_u.got[2]});
        chk("marking", 32'h1, {31'h0, serialOut});
        bus(1'b1, ADR_CMD, 32'h1);
        chk("shifter busy", 32'h0, {31'h0, serviceReq[2]});
        for (k = 0; k < 200 && rem_u.got.size() < 4; k++) @(posedge clk);
        chk("resumed", 32'h96, {24'h0, rem_u.got[3]});
        repeat (2) @(posedge clk);
        chk("shifter empty", 32'h1, {31'h0, serviceReq[2]});
        $display("test delay and hold done");
        close_out();
    end
endmodule
